// >>> sim/rat_resolver_model.sv
/*
 * Resolver sensor model: sine and cosine windings coupled to the
 * excitation. Assumes the bench sets shaft angle and coupling amplitude.
 */
`timescale 1ns/1ps

module rat_resolver_model (
  input wire logic clock,
  input wire logic [15:0] excitation_pair,
  input wire logic [15:0] shaft_angle,
  input wire logic [15:0] coupling,
  output logic [15:0] sine_return_pair,
  output logic [15:0] cosine_return_pair
);
  real th;
  int car;

  initial begin
    sine_return_pair = 16'h0000;
    cosine_return_pair = 16'h0000;
  end

  // Carrier follows excitation sign; envelope carries the angle
  always @(posedge clock) begin
    th = 6.283185307 * shaft_angle / 65536.0;
    car = ($signed(excitation_pair) < 0) ? -1 : 1;
    sine_return_pair <= 16'(car * $rtoi(coupling * $sin(th)));
    cosine_return_pair <= 16'(car * $rtoi(coupling * $cos(th)));
  end
endmodule

// >>> sim/resolver_angle_tracker_tb_top.sv
/*
 * Self-checking bench of the resolver angle tracker: register file,
 * refusals, interrupt and measurements against an ideal angle model.
 * Assumes a shortened reference period and the sensor model beside it.
 */
`timescale 1ns/1ps

`include "rat_defs.svh"

module resolver_angle_tracker_tb_top;
  import rat_pkg::*;

  // ****************************************
  // Signals and model state
  // ****************************************
  // Short period keeps the run brief; all timing follows from it
  localparam int PER = 256;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] theta = 16'h0008;
  logic [15:0] amp = 16'h4e20;
  logic [31:0] rd_data, pos_fb;
  logic [15:0] sin_ret, cos_ret, exc, el_ang, mech_ang, comm_ang, ofs, prev;
  logic pos_valid, fault, from_res, irq;
  logic [31:0] sh [0:9];
  logic [24:0] tbl [0:13] = '{25'h0_00_0003, 25'h1_00_0002, 25'h1_00_0000, 25'h1_00_0001, 25'h0_0c_270f,
    25'h1_0c_2710, 25'h1_0c_ffff, 25'h0_08_0000, 25'h0_08_0001, 25'h0_08_000d, 25'h0_08_000e,
    25'h1_08_000c, 25'h1_08_0002, 25'h1_08_0006};
  int n_fail = 0, compares = 0, turns = 0, cyc = 0, half = 1, cycles = 0;
  logic signed [15:0] exc_max = 16'sh8000;

  rat_top #(.EXC_PERIOD_CYCLES(PER)) u_dut (.clock(clock), .srst(srst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sine_return_pair(sin_ret), .cosine_return_pair(cos_ret),
    .excitation_pair(exc), .electrical_angle(el_ang), .position_feedback(pos_fb),
    .position_feedback_valid(pos_valid), .mechanical_angle(mech_ang), .commutation_angle(comm_ang),
    .commutation_from_resolver(from_res), .sensor_fault(fault), .irq(irq));

  rat_resolver_model u_sensor (.clock(clock), .excitation_pair(exc), .shaft_angle(theta), .coupling(amp),
    .sine_return_pair(sin_ret), .cosine_return_pair(cos_ret));

  always #2 clock = ~clock;

  // Reference peak, read away from the launching edge
  always @(negedge clock) begin
    if (!srst && $signed(exc) > exc_max) begin
      exc_max <= exc;
    end
  end

  // Hang guard: the sequence needs about 8000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // Arctangent carries a couple of LSB of error
  task automatic chk_near(input string name, input logic [15:0] exp, input logic [15:0] got);
    logic [15:0] d;
    d = got - exp;
    compares++;
    if ($isunknown(got) || (d > 16'h0002 && d < 16'hfffe)) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk($sformatf("register %h", a), exp, d);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clock);
    #1 chk("interrupt", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic wait_valid;
    int k;
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (pos_valid !== 1'b1 && k < 2 * PER);
    chk("valid pulse", 32'h1, {31'h0, pos_valid});
  endtask

  task automatic measure(input logic [15:0] th);
    int m;
    @(posedge clock);
    theta <= th;
    wait_valid();
    if (prev[15:14] == 2'b11 && th[15:14] == 2'b00) begin
      turns++;
      cyc = (cyc + 1) % half;
    end else if (prev[15:14] == 2'b00 && th[15:14] == 2'b11) begin
      turns--;
      cyc = (cyc + half - 1) % half;
    end
    prev = th;
    // Arctangent gain of about 1.647 on the return amplitude
    m = int'(amp) * 1647 / 1000;
    chk("turn count", {16'h0, 16'(turns)}, {16'h0, pos_fb[31:16]});
    chk("sensor fault", {31'h0, m < int'(`RAT_MAG_MIN) || m > int'(`RAT_MAG_MAX)}, {31'h0, fault});
    if (amp > 16'h1000) begin
      chk_near("electrical angle", th, el_ang);
      chk_near("position angle", th, pos_fb[15:0]);
      chk_near("mechanical angle", 16'((cyc * 65536 + int'(th)) / half), mech_ang);
      chk_near("commutation angle", th + ofs, comm_ang);
    end
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [15:0] th, step;
    int t0;
    d = $urandom(32'h7c81);
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    rdchk(`RAT_ADDR_STATUS, 32'h0);
    rdchk(`RAT_ADDR_SRC, 32'h1);
    rdchk(`RAT_ADDR_OFS, 32'h1555);
    rdchk(`RAT_ADDR_POLES, 32'h2);
    rdchk(`RAT_ADDR_LEVEL, 32'h7530);
    rdchk(`RAT_ADDR_ENABLE, 32'h0);
    rdchk(8'h28, 32'h0);
    rdchk(`RAT_ADDR_CLEAR, 32'h0);
    sh[0] = 32'h1;
    sh[2] = 32'h2;
    sh[3] = 32'h7530;
    foreach (tbl[i]) begin
      wr(`RAT_ADDR_CLEAR, 32'h4);
      wr(tbl[i][23:16], {16'h0, tbl[i][15:0]});
      if (tbl[i][24]) begin
        sh[tbl[i][21:18]] = {16'h0, tbl[i][15:0]};
      end
      rdchk(tbl[i][23:16], sh[tbl[i][21:18]]);
      rd(`RAT_ADDR_STATUS, d);
      chk("refusal flag", {29'h0, ~tbl[i][24], 2'b00}, d & 32'h4);
      chk("commutation source", {31'h0, sh[0] == 32'h1}, {31'h0, from_res});
    end
    wr(`RAT_ADDR_ENABLE, 32'hffff_fffc);
    rdchk(`RAT_ADDR_ENABLE, 32'h4);
    irq_is(1'b0);
    wr(`RAT_ADDR_POLES, 32'h3);
    irq_is(1'b1);
    wr(`RAT_ADDR_ENABLE, 32'h0);
    irq_is(1'b0);
    wr(`RAT_ADDR_ENABLE, 32'h4);
    irq_is(1'b1);
    wr(`RAT_ADDR_CLEAR, 32'h4);
    irq_is(1'b0);
    ofs = 16'($urandom);
    wr(`RAT_ADDR_OFS, {16'h0, ofs});
    wr(`RAT_ADDR_POLES, 32'h6);
    cyc = 0;
    half = 3;
    prev = 16'h0008;
    wait_valid();
    t0 = cycles;
    wait_valid();
    chk("reference period", 32'h1, {31'h0, (cycles - t0 == PER) || (cycles - t0 == PER + 1)});
    measure(16'hf008);
    measure(16'h0008);
    measure(16'hf008);
    th = 16'hf008;
    for (int i = 0; i < 24; i++) begin
      step = 16'($urandom_range(32'h2800, 32'h0800)) & 16'hfff0;
      th = (i < 12) ? th + step : th - step;
      measure(th); // [EXCITATION_PAIR]
    end
    amp <= 16'h03e8;
    measure(prev);
    rd(`RAT_ADDR_STATUS, d);
    chk("fault status", 32'h1, d & 32'h1);
    chk("angle status", 32'h2, d & 32'h2);
    amp <= 16'h4e20;
    measure(prev);
    chk("excitation peak", 32'(32767 * int'(sh[3]) / 65536), {16'h0, exc_max});
    complete_run();
  end
endmodule

// >>> src/rat_atan.sv
/*
 * Iterative vectoring arctangent: angle of (x, y) as a 16-bit turn
 * fraction and the scaled vector length.
 * Assumes start only while idle; a start during a run is ignored.
 */
`timescale 1ns/1ps

`include "rat_defs.svh"

module rat_atan
  import rat_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic start,
  input wire logic signed [15:0] x_in,
  input wire logic signed [15:0] y_in,
  output logic done,
  output logic [15:0] angle,
  output logic [16:0] mag
);

  // ****************************************
  // Arctangent steps, one turn is 2^16
  // ****************************************
  function automatic logic [15:0] atan_step(input logic [3:0] i);
    case (i)
      4'h0: atan_step = 16'h2000;
      4'h1: atan_step = 16'h12e4;
      4'h2: atan_step = 16'h09fb;
      4'h3: atan_step = 16'h0511;
      4'h4: atan_step = 16'h028b;
      4'h5: atan_step = 16'h0146;
      4'h6: atan_step = 16'h00a3;
      4'h7: atan_step = 16'h0051;
      4'h8: atan_step = 16'h0029;
      4'h9: atan_step = 16'h0014;
      4'ha: atan_step = 16'h000a;
      4'hb: atan_step = 16'h0005;
      4'hc: atan_step = 16'h0003;
      4'hd: atan_step = 16'h0001;
      4'he: atan_step = 16'h0001;
      default: atan_step = 16'h0000;
    endcase
  endfunction

  rat_cordic_s s;
  rat_cordic_s n;

  always_comb begin
    n = s;
    n.done = 1'b0;
    if (srst) begin
      n = '0;
    end else begin
      case (s.st)
        CS_IDLE: begin
          if (start) begin
            // Left half plane is pre-rotated by half a turn
            if (x_in[15]) begin
              n.x = -18'(x_in);
              n.y = -18'(y_in);
              n.z = 16'h8000;
            end else begin
              n.x = 18'(x_in);
              n.y = 18'(y_in);
              n.z = 16'h0000;
            end
            n.iter = 4'h0;
            n.st = CS_RUN;
          end
        end
        CS_RUN: begin
          if (!s.y[17]) begin
            n.x = s.x + (s.y >>> s.iter);
            n.y = s.y - (s.x >>> s.iter);
            n.z = s.z + atan_step(s.iter);
          end else begin
            n.x = s.x - (s.y >>> s.iter);
            n.y = s.y + (s.x >>> s.iter);
            n.z = s.z - atan_step(s.iter);
          end
          n.iter = s.iter + 4'h1;
          if (s.iter == 4'hf) begin
            n.st = CS_IDLE;
            n.done = 1'b1;
            n.angle = n.z;
            n.mag = n.x[16:0];
          end
        end
        default: n.st = CS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    s <= n;
  end

  assign done = s.done;
  assign angle = s.angle;
  assign mag = s.mag;

  chk_atan_latency: assert property (@(posedge clock) disable iff (srst) // [R5]
    (s.st == CS_IDLE && start) |-> ##17 s.done)
    else $error("arctangent result not ready 17 cycles after start");

endmodule

// >>> src/rat_defs.svh
/*
 * Offsets, field positions, reset values and timing figures of the
 * resolver angle tracker. Assumes a 250 MHz system clock.
 */
`ifndef RAT_DEFS_SVH
`define RAT_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define RAT_CLK_FREQ_HZ 250000000
`define RAT_EXC_FREQ_HZ 8000
`define RAT_SAMPLE_IDX 5'h08

// ****************************************
// Register offsets
// ****************************************
`define RAT_ADDR_SRC 8'h00
`define RAT_ADDR_OFS 8'h04
`define RAT_ADDR_POLES 8'h08
`define RAT_ADDR_LEVEL 8'h0c
`define RAT_ADDR_ANGLE 8'h10
`define RAT_ADDR_POS 8'h14
`define RAT_ADDR_MECH 8'h18
`define RAT_ADDR_STATUS 8'h1c
`define RAT_ADDR_CLEAR 8'h20
`define RAT_ADDR_ENABLE 8'h24

// ****************************************
// Reset values and limits
// ****************************************
`define RAT_RST_SRC 8'h01
`define RAT_RST_OFS 16'h1555
`define RAT_RST_POLES 16'h0002
`define RAT_RST_LEVEL 16'h7530
`define RAT_SRC_MAX 8'h02
`define RAT_SRC_RESOLVER 8'h01
`define RAT_POLES_MIN 16'h0002
`define RAT_POLES_MAX 16'h000c
`define RAT_LEVEL_MIN 16'h2710
`define RAT_MAG_MIN 17'h01000
`define RAT_MAG_MAX 17'h1c000

// ****************************************
// Status bits
// ****************************************
`define RAT_ST_FAULT 0
`define RAT_ST_ANGLE 1
`define RAT_ST_CFG 2

`endif

// >>> src/rat_pkg.sv
/*
 * Types of the resolver angle tracker: state records and modes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rat_pkg;

  typedef enum logic {CS_IDLE, CS_RUN} rat_cordic_e;

  typedef struct packed {
    rat_cordic_e st;
    logic [3:0] iter;
    logic signed [17:0] x;
    logic signed [17:0] y;
    logic [15:0] z;
    logic done;
    logic [15:0] angle;
    logic [16:0] mag;
  } rat_cordic_s;

  typedef struct packed {
    logic [7:0] src;
    logic src_res;
    logic [15:0] ofs;
    logic [15:0] poles;
    logic [15:0] level;
    logic [31:0] phase;
    logic [15:0] exc;
    logic start;
    logic [15:0] sin_smp;
    logic [15:0] cos_smp;
    logic [15:0] angle;
    logic [15:0] turns;
    logic [2:0] cyc;
    logic [31:0] pos;
    logic pos_valid;
    logic [15:0] mech;
    logic [15:0] comm;
    logic fault;
    logic [2:0] status;
    logic [2:0] enable;
    logic irq;
    logic [31:0] rd_data;
  } rat_state_s;

endpackage

// >>> src/rat_top.sv
/*
 * Resolver angle tracker: excitation reference, synchronous sampling of
 * the return pairs, arctangent angle, turn counting and register file.
 * Assumes the return samples are signed words synchronous to clock and
 * already settled at the reference peak.
 */
// Behaviour
// R1 - Electrical angle is a 16-bit word, one full scale per electrical cycle.
// R2 - Multi-turn position counts angle rollovers and extends the angle word.
// R3 - Multi-turn position drives the position loop feedback output.
// R4 - Pole count holds twice the pole pairs, accepted from 2 to 12.
// R5 - Angle comes from arctangent of measured sine and cosine amplitudes.
// R6 - Excitation reference runs at 8 kHz; sampling follows its period.
// R7 - Excitation level accepts 10000 to 65535, default 30000.
// R8 - Inconsistent return amplitudes raise a sensor fault flag.
// R9 - Mechanical angle is the electrical angle scaled by the pole count.
// R10 - Wrap high-to-low counts a turn up, low-to-high counts it down.
`timescale 1ns/1ps

`include "rat_defs.svh"

module rat_top
  import rat_pkg::*;
#(
  parameter int EXC_PERIOD_CYCLES = `RAT_CLK_FREQ_HZ / `RAT_EXC_FREQ_HZ
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic [15:0] sine_return_pair,
  input wire logic [15:0] cosine_return_pair,
  output logic [15:0] excitation_pair,
  output logic [15:0] electrical_angle,
  output logic [31:0] position_feedback,
  output logic position_feedback_valid,
  output logic [15:0] mechanical_angle,
  output logic [15:0] commutation_angle,
  output logic commutation_from_resolver,
  output logic sensor_fault,
  output logic irq
);

  // ****************************************
  // Constants and helpers
  // ****************************************
  // Floor keeps the period at or just above the nominal count
  localparam logic [63:0] PHASE_INC_W = 64'h1_0000_0000 / 64'(EXC_PERIOD_CYCLES);
  localparam logic [31:0] PHASE_INC = PHASE_INC_W[31:0];

  function automatic logic signed [15:0] sine_at(input logic [4:0] idx);
    logic [3:0] k;
    logic [15:0] m;
    k = idx[3] ? 4'h8 - {1'b0, idx[2:0]} : {1'b0, idx[2:0]};
    case (k)
      4'h0: m = 16'h0000;
      4'h1: m = 16'h18f9;
      4'h2: m = 16'h30fc;
      4'h3: m = 16'h471d;
      4'h4: m = 16'h5a82;
      4'h5: m = 16'h6a6e;
      4'h6: m = 16'h7642;
      4'h7: m = 16'h7d8a;
      default: m = 16'h7fff;
    endcase
    sine_at = idx[4] ? -$signed(m) : $signed(m);
  endfunction

  // Reciprocal of pole pairs in 1/65536 units
  function automatic logic [16:0] recip(input logic [2:0] pairs);
    case (pairs)
      3'h2: recip = 17'h08000;
      3'h3: recip = 17'h05555;
      3'h4: recip = 17'h04000;
      3'h5: recip = 17'h03333;
      3'h6: recip = 17'h02aab;
      default: recip = 17'h10000;
    endcase
  endfunction

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // ****************************************
  // Arctangent engine
  // ****************************************
  logic cordic_done;
  logic [15:0] cordic_angle;
  logic [16:0] cordic_mag;

  rat_state_s s;
  rat_state_s n;

  rat_atan u_atan (
    .clock(clock),
    .srst(srst),
    .start(s.start),
    .x_in(s.cos_smp),
    .y_in(s.sin_smp),
    .done(cordic_done),
    .angle(cordic_angle),
    .mag(cordic_mag)
  );

  // ****************************************
  // Next state
  // ****************************************
  logic carry;
  logic signed [32:0] prod;
  logic [35:0] mprod;
  logic [2:0] pairs;
  logic [2:0] cyc_new;
  logic [15:0] turns_new;
  logic [2:0] set;
  logic [2:0] clr;
  logic bad;

  always_comb begin
    n = s;
    carry = 1'b0;
    prod = '0;
    mprod = '0;
    pairs = s.poles[3:1];
    cyc_new = s.cyc;
    turns_new = s.turns;
    set = '0;
    clr = '0;
    bad = 1'b0;
    n.start = 1'b0;
    n.pos_valid = 1'b0;
    n.rd_data = '0;
    if (srst) begin
      n = '0;
      n.src = `RAT_RST_SRC;
      n.src_res = 1'b1;
      n.ofs = `RAT_RST_OFS;
      n.poles = `RAT_RST_POLES;
      n.level = `RAT_RST_LEVEL;
    end else begin
      // Reference phase and scaled sine sample
      {carry, n.phase} = {1'b0, s.phase} + {1'b0, PHASE_INC}; // [R6]
      prod = sine_at(n.phase[31:27]) * $signed({1'b0, s.level}); // [R7]
      n.exc = prod[31:16];
      // Sample at the reference peak; demodulated sign carries the quadrant
      if (n.phase[31:27] == `RAT_SAMPLE_IDX && s.phase[31:27] != `RAT_SAMPLE_IDX) begin // [R6]
        n.start = 1'b1;
        n.sin_smp = sine_return_pair; // [R5]
        n.cos_smp = cosine_return_pair;
      end
      if (cordic_done) begin
        n.angle = cordic_angle; // [R1]
        if (s.angle[15:14] == 2'b11 && cordic_angle[15:14] == 2'b00) begin // [R10]
          turns_new = s.turns + 16'h0001;
          cyc_new = (s.cyc >= pairs - 3'h1) ? 3'h0 : s.cyc + 3'h1;
        end else if (s.angle[15:14] == 2'b00 && cordic_angle[15:14] == 2'b11) begin // [R10]
          turns_new = s.turns - 16'h0001;
          cyc_new = (s.cyc == 3'h0) ? pairs - 3'h1 : s.cyc - 3'h1;
        end
        n.turns = turns_new; // [R2]
        n.cyc = cyc_new;
        n.pos = {turns_new, cordic_angle}; // [R2]
        n.pos_valid = 1'b1; // [R3]
        mprod = 36'({cyc_new, cordic_angle}) * 36'(recip(pairs)); // [R9]
        n.mech = mprod[31:16];
        n.comm = cordic_angle + s.ofs;
        // Too weak or overdriven return means a wrong ratio or open winding
        bad = (cordic_mag < `RAT_MAG_MIN) || (cordic_mag > `RAT_MAG_MAX); // [R8]
        n.fault = bad;
        set[`RAT_ST_FAULT] = bad; // [R8]
        set[`RAT_ST_ANGLE] = 1'b1;
      end
      // Register writes; out-of-range settings are refused, old value kept
      if (wr_en) begin
        case (addr)
          `RAT_ADDR_SRC: begin
            if (wr_data[7:0] <= `RAT_SRC_MAX) begin
              n.src = wr_data[7:0];
              n.src_res = (wr_data[7:0] == `RAT_SRC_RESOLVER);
            end else begin
              set[`RAT_ST_CFG] = 1'b1;
            end
          end
          `RAT_ADDR_OFS: n.ofs = wr_data[15:0];
          `RAT_ADDR_POLES: begin
            if (in_range(wr_data[15:0], `RAT_POLES_MIN, `RAT_POLES_MAX) && !wr_data[0]) begin // [R4]
              n.poles = wr_data[15:0];
              n.cyc = 3'h0;
            end else begin
              set[`RAT_ST_CFG] = 1'b1;
            end
          end
          `RAT_ADDR_LEVEL: begin
            if (in_range(wr_data[15:0], `RAT_LEVEL_MIN, 16'hffff)) begin // [R7]
              n.level = wr_data[15:0];
            end else begin
              set[`RAT_ST_CFG] = 1'b1;
            end
          end
          `RAT_ADDR_CLEAR: clr = wr_data[2:0];
          `RAT_ADDR_ENABLE: n.enable = wr_data[2:0];
          default: ;
        endcase
      end
      // New events win over a clear in the same cycle
      n.status = (s.status & ~clr) | set;
      n.irq = |(n.status & n.enable);
      if (rd_en) begin
        case (addr)
          `RAT_ADDR_SRC: n.rd_data = {24'h000000, s.src};
          `RAT_ADDR_OFS: n.rd_data = {16'h0000, s.ofs};
          `RAT_ADDR_POLES: n.rd_data = {16'h0000, s.poles};
          `RAT_ADDR_LEVEL: n.rd_data = {16'h0000, s.level};
          `RAT_ADDR_ANGLE: n.rd_data = {16'h0000, s.angle};
          `RAT_ADDR_POS: n.rd_data = s.pos;
          `RAT_ADDR_MECH: n.rd_data = {16'h0000, s.mech};
          `RAT_ADDR_STATUS: n.rd_data = {29'h00000000, s.status};
          `RAT_ADDR_ENABLE: n.rd_data = {29'h00000000, s.enable};
          default: n.rd_data = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    s <= n;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rd_data = s.rd_data;
  assign excitation_pair = s.exc;
  assign electrical_angle = s.angle;
  assign position_feedback = s.pos;
  assign position_feedback_valid = s.pos_valid;
  assign mechanical_angle = s.mech;
  assign commutation_angle = s.comm;
  assign commutation_from_resolver = s.src_res;
  assign sensor_fault = s.fault;
  assign irq = s.irq;

  // ****************************************
  // Checks
  // ****************************************
  logic tick_q;
  logic tick_seen;
  logic [31:0] per_cnt;

  always_ff @(posedge clock) begin
    if (srst) begin
      tick_q <= 1'b0;
      tick_seen <= 1'b0;
      per_cnt <= '0;
    end else begin
      tick_q <= carry;
      if (tick_q) begin
        tick_seen <= 1'b1;
        per_cnt <= '0;
      end else begin
        per_cnt <= per_cnt + 32'h1;
      end
    end
  end

  chk_angle_word: assert property (@(posedge clock) disable iff (srst) // [R1]
    cordic_done |=> electrical_angle == $past(cordic_angle))
    else $error("angle word not taken from arctangent result");

  chk_turn_up: assert property (@(posedge clock) disable iff (srst) // [R10]
    (cordic_done && s.angle[15:14] == 2'b11 && cordic_angle[15:14] == 2'b00)
    |=> s.turns == $past(s.turns) + 16'h0001)
    else $error("forward wrap did not count a turn up");

  chk_turn_down: assert property (@(posedge clock) disable iff (srst) // [R10]
    (cordic_done && s.angle[15:14] == 2'b00 && cordic_angle[15:14] == 2'b11)
    |=> s.turns == $past(s.turns) - 16'h0001)
    else $error("reverse wrap did not count a turn down");

  chk_pos_feed: assert property (@(posedge clock) disable iff (srst) // [R2]
    position_feedback_valid |-> position_feedback == {s.turns, electrical_angle})
    else $error("position feedback is not turns over angle");

  chk_feed_timing: assert property (@(posedge clock) disable iff (srst) // [R3]
    cordic_done |=> position_feedback_valid ##1 !position_feedback_valid)
    else $error("feedback strobe not one cycle after result");

  chk_pole_range: assert property (@(posedge clock) disable iff (srst) // [R4]
    s.poles >= `RAT_POLES_MIN && s.poles <= `RAT_POLES_MAX && !s.poles[0])
    else $error("pole count outside accepted set");

  chk_sample_sync: assert property (@(posedge clock) disable iff (srst) // [R6]
    s.start |-> s.phase[31:27] == `RAT_SAMPLE_IDX && $past(s.phase[31:27]) != `RAT_SAMPLE_IDX)
    else $error("sampling not at reference peak");

  chk_exc_period: assert property (@(posedge clock) disable iff (srst) // [R6]
    (tick_q && tick_seen) |-> (per_cnt >= 32'(EXC_PERIOD_CYCLES - 1)) && (per_cnt <= 32'(EXC_PERIOD_CYCLES)))
    else $error("reference period off nominal");

  chk_level_range: assert property (@(posedge clock) disable iff (srst) // [R7]
    s.level >= `RAT_LEVEL_MIN)
    else $error("excitation level below minimum");

  chk_fault_set: assert property (@(posedge clock) disable iff (srst) // [R8]
    (cordic_done && (cordic_mag < `RAT_MAG_MIN || cordic_mag > `RAT_MAG_MAX))
    |=> sensor_fault && s.status[`RAT_ST_FAULT])
    else $error("bad amplitude not flagged");

  chk_mech_scale: assert property (@(posedge clock) disable iff (srst) // [R9]
    (position_feedback_valid && s.poles == 16'h0002) |-> mechanical_angle == electrical_angle)
    else $error("two-pole mechanical angle differs from electrical");

  chk_irq_level: assert property (@(posedge clock) disable iff (srst)
    irq == |(s.status & s.enable))
    else $error("interrupt does not follow enabled status");

  // Refused settings must leave the old value and raise the flag
  chk_pole_keep: assert property (@(posedge clock) disable iff (srst) // [R4]
    (wr_en && addr == `RAT_ADDR_POLES
     && (!in_range(wr_data[15:0], `RAT_POLES_MIN, `RAT_POLES_MAX) || wr_data[0]))
    |=> s.poles == $past(s.poles))
    else $error("refused pole count was taken");

  chk_pole_flag: assert property (@(posedge clock) disable iff (srst) // [R4]
    (wr_en && addr == `RAT_ADDR_POLES
     && (!in_range(wr_data[15:0], `RAT_POLES_MIN, `RAT_POLES_MAX) || wr_data[0]))
    |=> s.status[`RAT_ST_CFG])
    else $error("refused pole count not flagged");

  chk_level_keep: assert property (@(posedge clock) disable iff (srst) // [R7]
    (wr_en && addr == `RAT_ADDR_LEVEL && wr_data[15:0] < `RAT_LEVEL_MIN)
    |=> s.level == $past(s.level))
    else $error("refused excitation level was taken");

  chk_exc_peak: assert property (@(posedge clock) disable iff (srst) // [R7]
    (s.phase[31:27] == `RAT_SAMPLE_IDX)
    |-> s.exc == 16'((32'h00007fff * {16'h0000, $past(s.level)}) >> 16))
    else $error("reference peak not scaled by level");

  chk_turn_hold: assert property (@(posedge clock) disable iff (srst) // [R10]
    (cordic_done && !(s.angle[15:14] == 2'b11 && cordic_angle[15:14] == 2'b00)
     && !(s.angle[15:14] == 2'b00 && cordic_angle[15:14] == 2'b11))
    |=> s.turns == $past(s.turns))
    else $error("turn count moved without a wrap");

  chk_comm_sum: assert property (@(posedge clock) disable iff (srst)
    cordic_done |=> commutation_angle == 16'($past(cordic_angle) + $past(s.ofs)))
    else $error("commutation angle is not angle plus offset");

endmodule
